// *** design/servo_cfg.svh ***
`ifndef SERVO_CFG_SVH
`define SERVO_CFG_SVH

// Register byte offsets
`define OFS_CTRL      12'h000
`define OFS_TARGET    12'h004
`define OFS_VEL       12'h008
`define OFS_ACC       12'h00c
`define OFS_KP        12'h010
`define OFS_KI        12'h014
`define OFS_KD        12'h018
`define OFS_KVFF      12'h01c
`define OFS_KAFF      12'h020
`define OFS_STATUS    12'h024
`define OFS_DES_POS   12'h028
`define OFS_ACT_POS   12'h02c
`define OFS_FERR      12'h030
`define OFS_DES_VEL   12'h034
`define OFS_CONTROL   12'h038

// Control register fields
`define CTRL_GO_BIT   0
`define CTRL_REL_BIT  1
`define CTRL_EN_BIT   2
`define CTRL_CLR_BIT  3

// Status fields
`define STAT_MOVE_BIT 0
`define STAT_EN_BIT   1

// Gains are Q8.8 style: product shifted right by this
`define GAIN_SHIFT    8

// Reset values
`define RST_VEL       32'h0000_0100
`define RST_ACC       32'h0000_0010
`define RST_GAIN      32'h0000_0000

// Servo period
`define SERVO_PERIOD_NS 100000
`define CLK_PERIOD_NS   10
`define SERVO_CYCLES    (`SERVO_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// *** design/servo_pkg.sv ***
package servo_pkg;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_TRAJ,
        PH_ERR,
        PH_LAW
    } phase_t;

    typedef logic signed [31:0] word_t;
    typedef logic signed [47:0] acc_t;
endpackage

// *** design/sat_mac.sv ***
`timescale 1ns/1ps
`include "servo_cfg.svh"
// Signed gain times value, scaled, then clamped to 32 bits
module sat_mac (
    // Operands
    input  wire logic signed [31:0] value,
    input  wire logic signed [31:0] gain,
    // Result
    output logic signed [31:0]      product
);
    logic signed [63:0] full;
    logic signed [63:0] scaled;
    wire                over;
    wire                under;

    // Full precision product then fixed-point scale
    assign full   = value * gain;
    assign scaled = full >>> `GAIN_SHIFT;
    assign over   = scaled > 64'sh0000_0000_7fff_ffff;
    assign under  = scaled < -64'sh0000_0000_8000_0000;
    // Clamp rather than wrap
    assign product = over  ? 32'sh7fff_ffff :
                     under ? -32'sh8000_0000 :
                     scaled[31:0];
endmodule

// *** design/pid_servo_trajectory_loop.sv ***
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "servo_cfg.svh"
module pid_servo_trajectory_loop (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Encoder position count
    input  wire logic [31:0] enc_pos,
    // Control word to DAC
    output logic      [31:0] dac_word,
    output logic             dac_strobe,
    output logic             moving
);
    ////////////////////////////////////////////////////////////////////
    // Registers
    logic                  enable;
    servo_pkg::word_t      target_reg;
    servo_pkg::word_t      vel_reg;
    servo_pkg::word_t      acc_reg;
    servo_pkg::word_t      kp;
    servo_pkg::word_t      ki;
    servo_pkg::word_t      kd;
    servo_pkg::word_t      kvff;
    servo_pkg::word_t      kaff;

    // Loop state
    servo_pkg::phase_t     phase;
    logic [15:0]           tick_cnt;
    servo_pkg::word_t      des_pos;
    servo_pkg::word_t      des_vel;
    servo_pkg::word_t      des_acc;
    servo_pkg::word_t      dest;
    servo_pkg::word_t      act_pos;
    servo_pkg::word_t      ferr;
    servo_pkg::word_t      prev_ferr;
    servo_pkg::word_t      integ;
    servo_pkg::word_t      control;

    ////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states
    wire        wr_en   = psel & penable & pwrite;
    wire        rd_en   = psel & penable & ~pwrite;
    wire        hit_ctrl  = paddr == `OFS_CTRL;
    wire        hit_tgt   = paddr == `OFS_TARGET;
    wire        hit_vel   = paddr == `OFS_VEL;
    wire        hit_acc   = paddr == `OFS_ACC;
    wire        hit_kp    = paddr == `OFS_KP;
    wire        hit_ki    = paddr == `OFS_KI;
    wire        hit_kd    = paddr == `OFS_KD;
    wire        hit_kvff  = paddr == `OFS_KVFF;
    wire        hit_kaff  = paddr == `OFS_KAFF;
    wire        hit_stat  = paddr == `OFS_STATUS;
    wire        hit_dpos  = paddr == `OFS_DES_POS;
    wire        hit_apos  = paddr == `OFS_ACT_POS;
    wire        hit_ferr  = paddr == `OFS_FERR;
    wire        hit_dvel  = paddr == `OFS_DES_VEL;
    wire        hit_cw    = paddr == `OFS_CONTROL;
    wire        mapped  = hit_ctrl | hit_tgt | hit_vel | hit_acc | hit_kp |
                          hit_ki | hit_kd | hit_kvff | hit_kaff |
                          hit_stat | hit_dpos | hit_apos | hit_ferr |
                          hit_dvel | hit_cw;
    wire        go      = wr_en & hit_ctrl & pwdata[`CTRL_GO_BIT];
    wire        go_rel  = pwdata[`CTRL_REL_BIT];
    wire        clr_int = wr_en & hit_ctrl & pwdata[`CTRL_CLR_BIT];

    // Read mux
    logic [31:0] rd_mux;
    assign rd_mux =
        hit_ctrl ? {29'h0, enable, 2'h0} :
        hit_tgt  ? target_reg :
        hit_vel  ? vel_reg :
        hit_acc  ? acc_reg :
        hit_kp   ? kp :
        hit_ki   ? ki :
        hit_kd   ? kd :
        hit_kvff ? kvff :
        hit_kaff ? kaff :
        hit_stat ? {30'h0, enable, moving} :
        hit_dpos ? des_pos :
        hit_apos ? act_pos :
        hit_ferr ? ferr :
        hit_dvel ? des_vel :
        hit_cw   ? control :
        32'h0000_0000;

    // Register writes; new velocity and acceleration act at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable     <= 1'b0;
            target_reg <= '0;
            vel_reg    <= `RST_VEL;
            acc_reg    <= `RST_ACC;
            kp         <= `RST_GAIN;
            ki         <= `RST_GAIN;
            kd         <= `RST_GAIN;
            kvff       <= `RST_GAIN;
            kaff       <= `RST_GAIN;
        end else if (wr_en) begin
            if (hit_ctrl) enable     <= pwdata[`CTRL_EN_BIT];
            if (hit_tgt)  target_reg <= pwdata;
            if (hit_vel)  vel_reg    <= pwdata;
            if (hit_acc)  acc_reg    <= pwdata;
            if (hit_kp)   kp         <= pwdata;
            if (hit_ki)   ki         <= pwdata;
            if (hit_kd)   kd         <= pwdata;
            if (hit_kvff) kvff       <= pwdata;
            if (hit_kaff) kaff       <= pwdata;
        end
    end

    // Bus answer registered so outputs come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Servo period timer
    localparam logic [15:0] PERIOD_LAST = 16'(`SERVO_CYCLES - 1);
    wire period_tick = tick_cnt == PERIOD_LAST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tick_cnt <= '0;
        else
            tick_cnt <= period_tick ? 16'h0000 : tick_cnt + 16'h0001;
    end

    // Phase sequencer: trajectory, then error, then control law
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= servo_pkg::PH_IDLE;
        end else begin
            case (phase)
                servo_pkg::PH_IDLE: begin
                    if (period_tick)
                        phase <= servo_pkg::PH_TRAJ;
                end
                servo_pkg::PH_TRAJ: phase <= servo_pkg::PH_ERR;
                servo_pkg::PH_ERR:  phase <= servo_pkg::PH_LAW;
                servo_pkg::PH_LAW:  phase <= servo_pkg::PH_IDLE;
                default:            phase <= servo_pkg::PH_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Trajectory generator
    servo_pkg::word_t remain;
    servo_pkg::word_t dist_abs;
    servo_pkg::word_t vmag;
    servo_pkg::word_t next_vmag;
    servo_pkg::word_t vmax;
    servo_pkg::word_t amag;
    servo_pkg::word_t acc_abs;
    logic [63:0]      brake_dist;
    logic             dir_pos;
    logic             decel;
    servo_pkg::word_t next_acc;

    assign remain   = dest - des_pos;
    assign dir_pos  = ~remain[31];
    assign dist_abs = dir_pos ? remain : -remain;
    assign vmag     = des_vel[31] ? -des_vel : des_vel;
    assign vmax     = vel_reg[31] ? -vel_reg : vel_reg;
    assign acc_abs  = acc_reg[31] ? -acc_reg : acc_reg;
    // Zero would stall the ramp forever; use one count instead
    assign amag     = (acc_abs == 32'sh0) ? 32'sh1 : acc_abs;
    // v^2/(2a) stopping distance, computed as v*v vs 2*a*d
    assign brake_dist = 64'(vmag) * 64'(vmag);
    assign decel = brake_dist >= 64'(2) * 64'(amag) * 64'(dist_abs);

    // Next speed: slow down near target, else ramp toward vmax
    always_comb begin
        next_vmag = vmag;
        if (decel)
            next_vmag = (vmag > amag) ? vmag - amag : 32'sh0;
        else if (vmag < vmax)
            next_vmag = (vmax - vmag > amag) ? vmag + amag : vmax;
        else if (vmag > vmax)
            next_vmag = (vmag - vmax > amag) ? vmag - amag : vmax;
        if (next_vmag > dist_abs)
            next_vmag = dist_abs;
        next_acc = (dir_pos ? next_vmag : -next_vmag) - des_vel;
    end

    // Move command and per-period trajectory step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dest    <= '0;
            des_pos <= '0;
            des_vel <= '0;
            des_acc <= '0;
            moving  <= 1'b0;
        end else if (go) begin
            // Absolute or relative destination
            dest   <= go_rel ? des_pos + target_reg : target_reg;
            moving <= 1'b1;
        end else if (phase == servo_pkg::PH_TRAJ && moving) begin
            des_vel <= dir_pos ? next_vmag : -next_vmag;
            des_acc <= next_acc;
            des_pos <= des_pos + (dir_pos ? next_vmag : -next_vmag);
            if (next_vmag == 32'sh0 && dist_abs == 32'sh0)
                moving <= 1'b0;
        end else if (phase == servo_pkg::PH_TRAJ) begin
            des_vel <= '0;
            des_acc <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Error, integral and derivative
    servo_pkg::acc_t  err_wide;
    servo_pkg::acc_t  int_wide;
    servo_pkg::word_t next_ferr;
    servo_pkg::word_t next_integ;
    servo_pkg::word_t deriv;

    assign err_wide  = 48'(des_pos) - 48'(act_pos);
    assign next_ferr = (err_wide > 48'sh0000_7fff_ffff) ? 32'sh7fff_ffff :
                       (err_wide < -48'sh0000_8000_0000) ? -32'sh8000_0000 :
                       err_wide[31:0];
    assign int_wide  = 48'(integ) + 48'(ferr);
    assign next_integ = (int_wide > 48'sh0000_7fff_ffff) ? 32'sh7fff_ffff :
                        (int_wide < -48'sh0000_8000_0000) ? -32'sh8000_0000 :
                        int_wide[31:0];
    assign deriv = 32'(48'(ferr) - 48'(prev_ferr));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_pos   <= '0;
            ferr      <= '0;
            prev_ferr <= '0;
            integ     <= '0;
        end else begin
            if (phase == servo_pkg::PH_TRAJ)
                act_pos <= enc_pos; // Sample encoder once per period
            if (phase == servo_pkg::PH_ERR) begin
                prev_ferr <= ferr;
                ferr      <= next_ferr;
            end
            if (clr_int || !enable)
                integ <= '0;
            else if (phase == servo_pkg::PH_LAW)
                integ <= next_integ;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Gain products
    servo_pkg::word_t p_term;
    servo_pkg::word_t i_term;
    servo_pkg::word_t d_term;
    servo_pkg::word_t v_term;
    servo_pkg::word_t a_term;

    sat_mac u_p (.value(ferr),      .gain(kp),   .product(p_term));
    sat_mac u_i (.value(next_integ), .gain(ki),  .product(i_term));
    sat_mac u_d (.value(deriv),     .gain(kd),   .product(d_term));
    sat_mac u_v (.value(des_vel),   .gain(kvff), .product(v_term));
    sat_mac u_a (.value(des_acc),   .gain(kaff), .product(a_term));

    // Sum in wide form, then clamp; wrapping would flip motor drive
    servo_pkg::acc_t sum_wide;
    servo_pkg::word_t next_control;
    assign sum_wide = 48'(p_term) + 48'(i_term) + 48'(d_term)
                    + 48'(v_term) + 48'(a_term);
    assign next_control =
        (sum_wide > 48'sh0000_7fff_ffff) ? 32'sh7fff_ffff :
        (sum_wide < -48'sh0000_8000_0000) ? -32'sh8000_0000 :
        sum_wide[31:0];

    // Control word out; zero when loop disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control    <= '0;
            dac_word   <= '0;
            dac_strobe <= 1'b0;
        end else begin
            dac_strobe <= phase == servo_pkg::PH_LAW;
            if (phase == servo_pkg::PH_LAW) begin
                control  <= enable ? next_control : 32'sh0;
                dac_word <= enable ? next_control : 32'h0;
            end
        end
    end
endmodule

// *** testbench/motor_driver_model.sv ***
`timescale 1ns/1ps
// Plant stand-in: driver plus encoder on the far side of the DAC
module motor_driver_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control word from the loop
    input  wire logic [31:0] dac_word,
    input  wire logic        dac_strobe,
    // Bench control: frozen shaft at a set count
    input  wire logic        frozen,
    input  wire logic [31:0] preset_pos,
    // Encoder count back to the loop
    output logic      [31:0] enc_pos
);
    // Shaft integrates the drive; frozen mode pins it for exact figures
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_pos <= 32'h0000_0000;
        end else if (frozen) begin
            enc_pos <= preset_pos;
        end else if (dac_strobe) begin
            enc_pos <= enc_pos + 32'($signed(dac_word) >>> 6);
        end
    end
endmodule

// *** testbench/pid_servo_trajectory_loop_asserts.sv ***
`timescale 1ns/1ps
module servo_loop_checker (
    // Clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Servo outputs
    input wire logic [31:0] dac_word,
    input wire logic        dac_strobe,
    input wire logic        moving
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] gap;
    logic        seen;
    // Cycles since last strobe; first strobe has no reference
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap  <= 16'h0000;
            seen <= 1'b0;
        end else if (dac_strobe) begin
            gap  <= 16'h0000;
            seen <= 1'b1;
        end else begin
            gap  <= gap + 16'h0001;
        end
    end
    property p_period; dac_strobe && seen |-> gap == 16'd9999; endproperty
    a_period: assert property (p_period)
        else $error("servo period not 10000 cycles");
    property p_pulse; dac_strobe |=> !dac_strobe [*8]; endproperty
    a_pulse: assert property (p_pulse)
        else $error("strobe repeated too soon");
    property p_word; !dac_strobe |-> $stable(dac_word); endproperty
    a_word: assert property (p_word)
        else $error("control word moved without strobe");
    property p_setup; psel && !penable |=> pready; endproperty
    a_setup: assert property (p_setup)
        else $error("no answer in first access cycle");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("ready held two cycles");
    property p_ready_ctx; pready |-> psel && penable; endproperty
    a_ready_ctx: assert property (p_ready_ctx)
        else $error("ready outside access phase");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err)
        else $error("error response without ready");
    property p_rdata; $changed(prdata) |-> pready && !pwrite; endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data changed outside a read");
    c_strobe: cover property (dac_strobe);
    c_err: cover property (pslverr);
    c_move: cover property ($rose(moving));
endmodule
bind pid_servo_trajectory_loop servo_loop_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dac_word(dac_word), .dac_strobe(dac_strobe), .moving(moving));

// *** testbench/test_pid_servo_trajectory_loop.sv ***
`timescale 1ns/1ps
`include "servo_cfg.svh"
module test_pid_servo_trajectory_loop;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        dac_strobe, moving, frozen, err_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, enc_pos, dac_word, preset_pos;
    logic [31:0] rq[$];
    logic [31:0] sq[$];
    int          failures, checks, seed, r;
    pid_servo_trajectory_loop u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enc_pos(enc_pos), .dac_word(dac_word),
        .dac_strobe(dac_strobe), .moving(moving));
    motor_driver_model u_plant (.pclk(pclk), .presetn(presetn),
        .dac_word(dac_word), .dac_strobe(dac_strobe), .frozen(frozen),
        .preset_pos(preset_pos), .enc_pos(enc_pos));
    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Bus master: hold the request until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready);
        err_seen = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic next_period;
        @(posedge pclk iff dac_strobe);
    endtask
    task automatic cmp(input string what, input logic [31:0] e,
                       input logic [31:0] s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Result watcher: oldest note against each answer
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && rq.size() > 0) begin
            cmp("prdata", rq.pop_front(), prdata);
        end
        if (dac_strobe && sq.size() > 0) begin
            cmp("dac_word", sq.pop_front(), dac_word);
        end
    end
    // Watchdog, past the nine servo periods the tests use
    initial begin
        repeat (98000) @(posedge pclk);
        failures++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        frozen = 1; preset_pos = 0; presetn = 0;
        failures = 0; checks = 0; seed = 41239;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFS_VEL, `RST_VEL);
        rd(`OFS_ACC, `RST_ACC);
        rd(`OFS_KP, `RST_GAIN);
        rd(12'hffc, 32'h0000_0000);
        cmp("pslverr", 32'd1, {31'd0, err_seen});
        $display("test registers done");
        // Proportional, derivative, then clamp of a huge product
        r = $random(seed) & 32'h3ff;
        next_period();
        apb(1'b1, `OFS_KP, 32'h0000_0200);
        apb(1'b1, `OFS_CTRL, 32'h0000_0004);
        preset_pos <= r;
        sq.push_back(-2 * r);
        next_period();
        rd(`OFS_FERR, -r);
        apb(1'b1, `OFS_KD, 32'h0000_0100);
        preset_pos <= r + 10;
        sq.push_back(-2 * (r + 10) - 10);
        next_period();
        apb(1'b1, `OFS_KD, 32'h0000_0000);
        apb(1'b1, `OFS_KP, 32'h7fff_ffff);
        preset_pos <= 32'h4000_0000;
        sq.push_back(32'h8000_0000);
        next_period();
        $display("test proportional done");
        // Integral builds period by period from a cleared start
        apb(1'b1, `OFS_KP, 32'h0000_0000);
        apb(1'b1, `OFS_KI, 32'h0000_0100);
        apb(1'b1, `OFS_CTRL, 32'h0000_000c);
        preset_pos <= 32'd20;
        sq.push_back(-32'sd20);
        sq.push_back(-32'sd40);
        next_period();
        next_period();
        $display("test integral done");
        // Move: feed-forward only, watch the ramp
        apb(1'b1, `OFS_KI, 32'h0000_0000);
        apb(1'b1, `OFS_KVFF, 32'h0000_0100);
        apb(1'b1, `OFS_KAFF, 32'h0000_0100);
        apb(1'b1, `OFS_ACC, 32'd10);
        apb(1'b1, `OFS_VEL, 32'd30);
        apb(1'b1, `OFS_TARGET, 32'd1000);
        apb(1'b1, `OFS_CTRL, 32'h0000_0005);
        sq.push_back(32'd20);
        sq.push_back(32'd30);
        next_period();
        cmp("moving", 32'd1, {31'd0, moving});
        next_period();
        // Relative retarget and softer braking while moving
        apb(1'b1, `OFS_ACC, 32'd5);
        apb(1'b1, `OFS_TARGET, 32'd20);
        apb(1'b1, `OFS_CTRL, 32'h0000_0007);
        sq.push_back(32'd10);
        next_period();
        rd(`OFS_DES_POS, 32'd45);
        $display("test move done");
        // Let the watcher take the last answer first
        @(posedge pclk);
        give_verdict();
    end
endmodule
